// file: clkb_defs.svh
/*
  constants for the clock buffer smbus configuration block: bus addresses,
  byte indices, reset values, field positions and arbitrary identity codes.
  assumes it is included by the host model, the testbench and the top design file only.
*/
// Contract
// R01 - host block write: start, write address, index N, count X, data N..N+X-1, stop
// R02 - target answers address dc hex for writes and dd hex for reads
// R03 - target acks address, index, count and each data byte; stores from N upward
// R04 - host block read: start, write address, index, repeated start, read address
// R05 - after read address ack, target sends count then bytes N upward
// R06 - host acks each read byte but the last, then nacks and stops
// R07 - byte 0 bits 7,6 output styles, bit 5 sleep sense; all reset 0
// R08 - byte 0 bits 3,1 latched mode strap; bit 2 bandwidth, bit 0 halving, reset 1
// R09 - byte 1 holds per pair enables, bit n for pair n, reset all ones
// R10 - pair runs only when its enable bit and its enable pin are both active
// R11 - byte 2 per pair stoppable select, 1 stoppable, reset all zeros
// R12 - byte 3 is spare with no function
// R13 - byte 4 read only: revision code high nibble, maker code low nibble
// R14 - writable readback length register sets read count, resets to 7
// R15 - sleep style 0: true leg high, complement undriven; style 1: both undriven
// R16 - stop style 0: park true high, complement low; style 1: both undriven
// R17 - host transfers only while the reference clock runs
// R18 - after reset all writable bits hold defaults and transfers are accepted
`ifndef CLKB_DEFS_SVH
`define CLKB_DEFS_SVH

// ==========================================
// bus addresses
`define CLKB_ADDR_WR 8'hdc
`define CLKB_ADDR_RD 8'hdd

// ==========================================
// byte indices
`define CLKB_IDX_MODE 8'h00
`define CLKB_IDX_OEN 8'h01
`define CLKB_IDX_STOP 8'h02
`define CLKB_IDX_SPARE 8'h03
`define CLKB_IDX_REV 8'h04
`define CLKB_IDX_DEVID 8'h05
`define CLKB_IDX_RBLEN 8'h06

// ==========================================
// reset values
`define CLKB_RST_MODE 8'h05
`define CLKB_RST_OEN 8'hff
`define CLKB_RST_STOP 8'h00
`define CLKB_RST_SPARE 8'h00
`define CLKB_RST_RBLEN 8'h07

// ==========================================
// byte 0 field positions
`define CLKB_B_SLEEP_STYLE 7
`define CLKB_B_STOP_STYLE 6
`define CLKB_B_SLEEP_SENSE 5
`define CLKB_B_MODE_HI 3
`define CLKB_B_BW 2
`define CLKB_B_MODE_LO 1
`define CLKB_B_HALVE 0

// ==========================================
// identity codes, values arbitrary
`define CLKB_REV_CODE 4'h3
`define CLKB_MAKER_CODE 4'h5
`define CLKB_DEV_CODE 8'h5a

// ==========================================
// counts
`define CLKB_BITS_PER_BYTE 4'h8
`define CLKB_LAST_BIT 4'h7

`endif

// file: clkb_host_model.sv
/*
  behavioural smbus host controller for the clock buffer configuration block.
  assumes an open drain data line with a pull-up and a running system clock.
*/
`include "clkb_defs.svh"

module clkb_host_model (
  // clock
  input wire logic clock_i,
  // bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o,
  // results
  output logic got_o,
  output logic [7:0] got_byte_o
);
  localparam int QTR = 5;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    got_o = 1'b0;
    got_byte_o = 8'h00;
  end

  // ==========================================
  // bus phases paced by the reference clock
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic put(input logic [7:0] v);
    got_byte_o <= v;
    got_o <= 1'b1;
    wt(1);
    got_o <= 1'b0;
  endtask

  task automatic bit_tx(input logic b);
    sda_low_o <= ~b;
    wt(QTR);
    scl_o <= 1'b1;
    wt(2 * QTR);
    scl_o <= 1'b0;
    wt(QTR);
  endtask

  task automatic bit_rx(output logic b);
    sda_low_o <= 1'b0;
    wt(QTR);
    scl_o <= 1'b1;
    wt(QTR);
    b = sda_i;
    wt(QTR);
    scl_o <= 1'b0;
    wt(QTR);
  endtask

  task automatic start_c();
    sda_low_o <= 1'b0;
    wt(QTR);
    scl_o <= 1'b1;
    wt(QTR);
    sda_low_o <= 1'b1;
    wt(QTR);
    scl_o <= 1'b0;
    wt(QTR);
  endtask

  task automatic stop_c();
    sda_low_o <= 1'b1;
    wt(QTR);
    scl_o <= 1'b1;
    wt(QTR);
    sda_low_o <= 1'b0;
    wt(2 * QTR);
  endtask

  // ==========================================
  // bytes and block transfers
  task automatic byte_tx(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) bit_tx(v[i]);
    bit_rx(a);
    put({7'h00, a});
  endtask

  task automatic byte_rx(input logic last);
    logic [7:0] v;
    for (int i = 7; i >= 0; i--) bit_rx(v[i]);
    put(v);
    bit_tx(last);
  endtask

  task automatic block_write(input logic [7:0] addr, input logic [7:0] idx,
                             input logic [7:0] d[$]);
    start_c();
    byte_tx(addr);
    byte_tx(idx);
    byte_tx(8'(d.size()));
    foreach (d[i]) byte_tx(d[i]);
    stop_c();
  endtask

  task automatic block_read(input logic [7:0] idx, input int n);
    start_c();
    byte_tx(`CLKB_ADDR_WR);
    byte_tx(idx);
    start_c();
    byte_tx(`CLKB_ADDR_RD);
    for (int i = 0; i < n; i++) byte_rx(i == n - 1);
    stop_c();
  endtask
endmodule

// file: clkb_pkg.sv
/*
  types for the clock buffer smbus configuration block.
  assumes clkb_defs.svh sits beside it.
*/
package clkb_pkg;

  // ==========================================
  // serial engine states
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} smb_state_t;

  // ==========================================
  // meaning of the byte being received
  typedef enum logic [1:0] {K_ADDR, K_INDEX, K_COUNT, K_DATA} byte_kind_t;

  // ==========================================
  // drive state of one output pair
  typedef enum logic [1:0] {
    PM_RUN,
    PM_PARK,
    PM_SLEEP_DRIVEN,
    PM_FLOAT
  } pair_mode_t;

  // ==========================================
  // configuration seen by the analog side
  typedef struct packed {
    logic sleep_output_style;
    logic stop_output_style;
    logic sleep_pin_sense;
    logic loop_bandwidth_select;
    logic input_halving_select;
  } clkb_cfg_t;

endpackage

// file: clkb_smb_edge.sv
/*
  smbus pin front end: two flop synchronisers on clock and data, then
  edge, start and stop detection on the synchronised levels.
  assumes pins are asynchronous to clock_i and much slower than it.
*/
module clkb_smb_edge (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // pins
  input wire logic scl_i,
  input wire logic sda_i,
  // events
  output logic scl_rise_o,
  output logic scl_fall_o,
  output logic start_o,
  output logic stop_o,
  output logic sda_level_o
);

  // ==========================================
  // synchronisers and history
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  always_ff @(posedge clock_i) begin
    scl_sync_reg <= {scl_sync_reg[0], scl_i};
    sda_sync_reg <= {sda_sync_reg[0], sda_i};
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  // ==========================================
  // events
  assign scl_rise_o = scl_sync_reg[1] & ~scl_prev_reg;
  assign scl_fall_o = ~scl_sync_reg[1] & scl_prev_reg;
  assign start_o = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
  assign stop_o = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];
  assign sda_level_o = sda_sync_reg[1];

endmodule

// file: clkb_testbench.sv
/*
  self-checking testbench for the clock buffer smbus configuration block.
  assumes clkb_host_model as the bus partner and a pulled-up data line.
*/
`include "clkb_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================
  // signals
  logic clock_i, rst_i, sleep_pin, halt_n, got, sda_o, sda_oe, scl, host_low;
  logic [7:0] pin_en, got_byte;
  logic [1:0] strap;
  wire logic sda;
  clkb_pkg::clkb_cfg_t cfg;
  clkb_pkg::pair_mode_t [7:0] pair_mode;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int n_compared = 0;

  assign sda = host_low ? 1'b0 : (sda_oe ? sda_o : 1'b1);

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  clkb_host_model host_u (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low),
    .got_o(got), .got_byte_o(got_byte));

  clkb_top dut_u (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .sleep_pin_i(sleep_pin), .output_halt_pin_n_i(halt_n),
    .pair_enable_pin_i(pin_en), .mode_strap_i(strap), .cfg_o(cfg), .pair_mode_o(pair_mode));

  // ==========================================
  // checking
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clock_i) begin
    if (got === 1'b1) check("bus byte", {8'h00, got_byte}, {8'h00, exp_q.pop_front()});
  end

  function automatic logic [15:0] pm_exp(input logic [7:0] b0, b1, b2, en,
                                         input logic slp, hn);
    logic [15:0] r;
    for (int n = 0; n < 8; n++) begin
      if (slp == b0[5]) r[2*n +: 2] = b0[7] ? clkb_pkg::PM_FLOAT : clkb_pkg::PM_SLEEP_DRIVEN;
      else if (!(b1[n] && en[n])) r[2*n +: 2] = clkb_pkg::PM_FLOAT;
      else if (!hn && b2[n]) r[2*n +: 2] = b0[6] ? clkb_pkg::PM_FLOAT : clkb_pkg::PM_PARK;
      else r[2*n +: 2] = clkb_pkg::PM_RUN;
    end
    return r;
  endfunction

  // ==========================================
  // transfers with their notes
  task automatic wr(input logic [7:0] idx, input logic [7:0] d[$]);
    repeat (d.size() + 3) exp_q.push_back(8'h00);
    host_u.block_write(`CLKB_ADDR_WR, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e[$]);
    repeat (3) exp_q.push_back(8'h00);
    foreach (e[i]) exp_q.push_back(e[i]);
    host_u.block_read(idx, e.size());
  endtask

  // ==========================================
  // main sequence
  initial begin
    logic [7:0] d[$];
    logic [7:0] e[$];
    logic [7:0] b0, sb;
    void'($urandom(32'h77459eaf));
    rst_i = 1'b1;
    sleep_pin = 1'b1;
    halt_n = 1'b1;
    pin_en = 8'hff;
    strap = 2'($urandom);
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    sb = {4'h0, strap[1], 1'b0, strap[0], 1'b0};
    b0 = `CLKB_RST_MODE | sb;
    e = '{8'h07, b0, 8'hff, 8'h00, 8'h00, {`CLKB_REV_CODE, `CLKB_MAKER_CODE}, `CLKB_DEV_CODE,
          8'h07};
    check("cfg", 16'(cfg), 16'h0003);
    rd(8'h00, e);
    d = '{};
    repeat (5) d.push_back(8'($urandom));
    wr(8'h00, d);
    e = '{8'h07, (d[0] & 8'hf5) | sb, d[1], d[2], d[3],
          {`CLKB_REV_CODE, `CLKB_MAKER_CODE}, `CLKB_DEV_CODE, 8'h07};
    rd(8'h00, e);
    exp_q.push_back(8'h01);
    host_u.start_c();
    host_u.byte_tx(8'hd8);
    host_u.stop_c();
    d = '{8'h02};
    wr(8'h06, d);
    e = '{8'h02, 8'h02, 8'h00};
    rd(8'h06, e);
    repeat (4) begin
      d = '{};
      repeat (3) d.push_back(8'($urandom));
      wr(8'h00, d);
      repeat (3) @(posedge clock_i);
      check("cfg", 16'(cfg), {11'h0, d[0][7], d[0][6], d[0][5], d[0][2], d[0][0]});
      repeat (8) begin
        sleep_pin <= 1'($urandom);
        halt_n <= 1'($urandom);
        pin_en <= 8'($urandom);
        repeat (6) @(posedge clock_i);
        check("pairs", pair_mode, pm_exp(d[0], d[1], d[2], pin_en, sleep_pin, halt_n));
      end
    end
    e = '{8'h02, d[1], d[2]};
    rd(8'h01, e);
    rst_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    check("cfg", 16'(cfg), 16'h0003);
    e = '{8'h07, b0, 8'hff, 8'h00, 8'h00, {`CLKB_REV_CODE, `CLKB_MAKER_CODE}, `CLKB_DEV_CODE,
          8'h07};
    rd(8'h00, e);
    repeat (10) @(posedge clock_i);
    check("pending notes", 16'(exp_q.size()), 16'h0000);
    final_report();
  end

  initial begin
    #3_000_000;
    err_count++;
    final_report();
  end
endmodule

// file: clkb_top.sv
/*
  smbus target with the configuration byte bank and per pair drive state
  of an eight pair clock fan-out buffer.
  assumes clock_i runs whenever the host talks and that sda is pulled up.
*/
`include "clkb_defs.svh"

module clkb_top (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // smbus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // control pins
  input wire logic sleep_pin_i,
  input wire logic output_halt_pin_n_i,
  input wire logic [7:0] pair_enable_pin_i,
  input wire logic [1:0] mode_strap_i,
  // analog side
  output clkb_pkg::clkb_cfg_t cfg_o,
  output clkb_pkg::pair_mode_t [7:0] pair_mode_o
);

  // ==========================================
  // pin front end
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic sda_lvl;

  clkb_smb_edge u_edge (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(start_ev),
    .stop_o(stop_ev),
    .sda_level_o(sda_lvl)
  );

  logic [1:0] sleep_sync_reg;
  logic [1:0] halt_sync_reg;
  logic [7:0] oe_sync0_reg;
  logic [7:0] oe_sync1_reg;
  logic [1:0] strap_sync0_reg;
  logic [1:0] strap_sync1_reg;

  always_ff @(posedge clock_i) begin
    sleep_sync_reg <= {sleep_sync_reg[0], sleep_pin_i};
    halt_sync_reg <= {halt_sync_reg[0], output_halt_pin_n_i};
    oe_sync0_reg <= pair_enable_pin_i;
    oe_sync1_reg <= oe_sync0_reg;
    strap_sync0_reg <= mode_strap_i;
    strap_sync1_reg <= strap_sync0_reg;
  end

  // ==========================================
  // byte bank
  logic [7:0] mode_reg;
  logic [7:0] oen_reg;
  logic [7:0] stop_reg;
  logic [7:0] spare_reg;
  logic [7:0] rblen_reg;
  logic [1:0] strap_reg;
  logic strap_done_reg;

  clkb_pkg::smb_state_t st_reg;
  clkb_pkg::byte_kind_t kind_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] idx_reg;
  logic wr_stb;
  logic addr_ok;
  logic [7:0] rd_byte;

  assign wr_stb = (st_reg == clkb_pkg::ST_RX) && scl_fall && (bit_cnt_reg == `CLKB_BITS_PER_BYTE)
                  && (kind_reg == clkb_pkg::K_DATA) && !start_ev && !stop_ev;
  assign addr_ok = (shift_reg == `CLKB_ADDR_WR) || (shift_reg == `CLKB_ADDR_RD); // R02

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode_reg <= `CLKB_RST_MODE; // R07 R08 R18
      oen_reg <= `CLKB_RST_OEN; // R09
      stop_reg <= `CLKB_RST_STOP; // R11
      spare_reg <= `CLKB_RST_SPARE; // R12
      rblen_reg <= `CLKB_RST_RBLEN; // R14
    end else if (wr_stb) begin
      unique case (idx_reg)
        `CLKB_IDX_MODE: mode_reg <= shift_reg; // R03
        `CLKB_IDX_OEN: oen_reg <= shift_reg;
        `CLKB_IDX_STOP: stop_reg <= shift_reg;
        `CLKB_IDX_SPARE: spare_reg <= shift_reg;
        `CLKB_IDX_RBLEN: rblen_reg <= shift_reg; // R14
        default: ; // read only or unmapped: R13
      endcase
    end
  end

  // mode strap caught once after reset release
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      strap_done_reg <= 1'b0;
      strap_reg <= 2'h0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      strap_reg <= strap_sync1_reg; // R08
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (idx_reg)
      `CLKB_IDX_MODE: begin
        rd_byte = mode_reg;
        rd_byte[`CLKB_B_MODE_HI] = strap_reg[1]; // R08
        rd_byte[`CLKB_B_MODE_LO] = strap_reg[0];
      end
      `CLKB_IDX_OEN: rd_byte = oen_reg;
      `CLKB_IDX_STOP: rd_byte = stop_reg;
      `CLKB_IDX_SPARE: rd_byte = spare_reg;
      `CLKB_IDX_REV: rd_byte = {`CLKB_REV_CODE, `CLKB_MAKER_CODE}; // R13
      `CLKB_IDX_DEVID: rd_byte = `CLKB_DEV_CODE;
      `CLKB_IDX_RBLEN: rd_byte = rblen_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  // ==========================================
  // serial engine
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_reg <= clkb_pkg::ST_IDLE; // R18
      kind_reg <= clkb_pkg::K_ADDR;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      idx_reg <= 8'h00;
    end else if (start_ev) begin
      st_reg <= clkb_pkg::ST_RX; // R01 R04
      kind_reg <= clkb_pkg::K_ADDR;
      bit_cnt_reg <= 4'h0;
    end else if (stop_ev) begin
      st_reg <= clkb_pkg::ST_IDLE;
    end else begin
      unique case (st_reg)
        clkb_pkg::ST_IDLE: ;
        clkb_pkg::ST_RX: begin
          if (scl_rise && bit_cnt_reg != `CLKB_BITS_PER_BYTE) begin
            shift_reg <= {shift_reg[6:0], sda_lvl};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == `CLKB_BITS_PER_BYTE) begin
            bit_cnt_reg <= 4'h0;
            if (kind_reg == clkb_pkg::K_ADDR && !addr_ok) begin
              st_reg <= clkb_pkg::ST_IDLE; // R02
            end else begin
              st_reg <= clkb_pkg::ST_ACK; // R03
            end
            if (kind_reg == clkb_pkg::K_INDEX) begin
              idx_reg <= shift_reg;
            end
            if (wr_stb) begin
              idx_reg <= idx_reg + 8'h01; // R03
            end
          end
        end
        clkb_pkg::ST_ACK: begin
          if (scl_fall) begin
            unique case (kind_reg)
              clkb_pkg::K_ADDR: begin
                if (shift_reg[0]) begin
                  st_reg <= clkb_pkg::ST_TX; // R05
                  shift_reg <= rblen_reg; // R14
                  kind_reg <= clkb_pkg::K_COUNT;
                end else begin
                  st_reg <= clkb_pkg::ST_RX;
                  kind_reg <= clkb_pkg::K_INDEX;
                end
              end
              clkb_pkg::K_INDEX: begin
                st_reg <= clkb_pkg::ST_RX;
                kind_reg <= clkb_pkg::K_COUNT;
              end
              clkb_pkg::K_COUNT,
              clkb_pkg::K_DATA: begin
                st_reg <= clkb_pkg::ST_RX;
                kind_reg <= clkb_pkg::K_DATA;
              end
            endcase
          end
        end
        clkb_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == `CLKB_LAST_BIT) begin
              st_reg <= clkb_pkg::ST_TXACK;
              bit_cnt_reg <= 4'h0;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        clkb_pkg::ST_TXACK: begin
          if (scl_rise && sda_lvl) begin
            st_reg <= clkb_pkg::ST_IDLE; // R06
          end else if (scl_fall) begin
            st_reg <= clkb_pkg::ST_TX; // R05
            shift_reg <= rd_byte;
            kind_reg <= clkb_pkg::K_DATA;
            idx_reg <= idx_reg + 8'h01;
          end
        end
      endcase
    end
  end

  // open drain data: only ever pulls low
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_o <= (st_reg == clkb_pkg::ST_ACK)
                  || (st_reg == clkb_pkg::ST_TX && !shift_reg[7]); // R03 R05
    end
  end

  // ==========================================
  // analog side controls
  logic sleep_act;
  logic halt_act;

  assign sleep_act = (sleep_sync_reg[1] == mode_reg[`CLKB_B_SLEEP_SENSE]); // R07
  assign halt_act = !halt_sync_reg[1];

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.sleep_output_style <= mode_reg[`CLKB_B_SLEEP_STYLE];
      cfg_o.stop_output_style <= mode_reg[`CLKB_B_STOP_STYLE];
      cfg_o.sleep_pin_sense <= mode_reg[`CLKB_B_SLEEP_SENSE];
      cfg_o.loop_bandwidth_select <= mode_reg[`CLKB_B_BW]; // R08
      cfg_o.input_halving_select <= mode_reg[`CLKB_B_HALVE];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pair
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          pair_mode_o[gi] <= clkb_pkg::PM_FLOAT;
        end else if (sleep_act) begin
          pair_mode_o[gi] <= mode_reg[`CLKB_B_SLEEP_STYLE] ? clkb_pkg::PM_FLOAT
                             : clkb_pkg::PM_SLEEP_DRIVEN; // R15
        end else if (!(oen_reg[gi] && oe_sync1_reg[gi])) begin
          pair_mode_o[gi] <= clkb_pkg::PM_FLOAT; // R10
        end else if (halt_act && stop_reg[gi]) begin
          pair_mode_o[gi] <= mode_reg[`CLKB_B_STOP_STYLE] ? clkb_pkg::PM_FLOAT
                             : clkb_pkg::PM_PARK; // R11 R16
        end else begin
          pair_mode_o[gi] <= clkb_pkg::PM_RUN;
        end
      end

      pair_run_a : assert property ( // R10
        @(posedge clock_i) disable iff (rst_i)
        pair_mode_o[gi] == clkb_pkg::PM_RUN |-> $past(oen_reg[gi] && oe_sync1_reg[gi]))
        else $error("pair runs while disabled");
    end
  endgenerate

  // ==========================================
  // checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  reset_defaults_a : assert property ( // R18
    $past(rst_i) |-> mode_reg == `CLKB_RST_MODE && oen_reg == `CLKB_RST_OEN
                     && stop_reg == `CLKB_RST_STOP && spare_reg == `CLKB_RST_SPARE
                     && st_reg == clkb_pkg::ST_IDLE)
    else $error("defaults wrong after reset");

  readback_len_a : assert property ( // R14
    $past(rst_i) |-> rblen_reg == `CLKB_RST_RBLEN)
    else $error("readback length default wrong");

  addr_match_a : assert property ( // R02
    st_reg == clkb_pkg::ST_ACK && kind_reg == clkb_pkg::K_ADDR
    |-> shift_reg == `CLKB_ADDR_WR || shift_reg == `CLKB_ADDR_RD)
    else $error("ack on foreign address");

  write_store_a : assert property ( // R03
    wr_stb && idx_reg == `CLKB_IDX_OEN
    |=> oen_reg == $past(shift_reg) && idx_reg == `CLKB_IDX_STOP)
    else $error("data byte not stored");

  count_first_a : assert property ( // R05
    st_reg == clkb_pkg::ST_ACK && kind_reg == clkb_pkg::K_ADDR && shift_reg[0] && scl_fall
    && !start_ev && !stop_ev |=> st_reg == clkb_pkg::ST_TX && shift_reg == rblen_reg)
    else $error("count not sent first");

  ro_code_a : assert property ( // R13
    idx_reg == `CLKB_IDX_REV |-> rd_byte == {`CLKB_REV_CODE, `CLKB_MAKER_CODE}
    ##1 (!$past(wr_stb) || (mode_reg == $past(mode_reg) && oen_reg == $past(oen_reg)
         && stop_reg == $past(stop_reg) && spare_reg == $past(spare_reg)
         && rblen_reg == $past(rblen_reg))))
    else $error("revision byte wrong");

  sleep_style_a : assert property ( // R15
    sleep_act && !mode_reg[`CLKB_B_SLEEP_STYLE]
    |=> pair_mode_o[0] == clkb_pkg::PM_SLEEP_DRIVEN
                                  && pair_mode_o[7] == clkb_pkg::PM_SLEEP_DRIVEN)
    else $error("sleep drive style wrong");

  stop_park_a : assert property ( // R16
    !sleep_act && halt_act && stop_reg[3] && oen_reg[3] && oe_sync1_reg[3]
    |=> pair_mode_o[3] == (mode_reg[`CLKB_B_STOP_STYLE] ? clkb_pkg::PM_FLOAT
                           : clkb_pkg::PM_PARK))
    else $error("stopped pair state wrong");

  ack_drive_a : assert property ( // R03
    st_reg == clkb_pkg::ST_ACK ##1 st_reg == clkb_pkg::ST_ACK |-> sda_oe_o)
    else $error("ack not driven");

endmodule
